// ---- diag_adc_defs.svh ----
`ifndef DIAG_ADC_DEFS_SVH
`define DIAG_ADC_DEFS_SVH

// Converter setup register layout.
`define SETUP_W          11
`define SETUP_RST        11'h400
`define SETUP_HI_MSB     10
`define SETUP_HI_LSB     8
`define SETUP_HI_VAL     3'h4
`define SETUP_LO_MSB     7
`define SETUP_LO_LSB     5
`define SETUP_LO_VAL     3'h0
`define SETUP_SEL_MSB    4
`define SETUP_SEL_LSB    0

// Status word layout as driven on the status_word_r output.
`define STAT_W           18
`define STAT_RST         18'h00000
`define STAT_BUSY_BIT    17
`define STAT_CH_MSB      16
`define STAT_CH_LSB      12
`define STAT_DATA_MSB    11
`define STAT_DATA_LSB    0

// Node select encodings.
`define NODE_TEMP_MAIN   5'h00
`define NODE_TEMP_FAR    5'h01
`define NODE_REFIN       5'h03
`define NODE_SECOND_INTERNAL_REFERENCE        5'h04
`define NODE_SENSE_P     5'h0D
`define NODE_SENSE_N     5'h0E
`define NODE_AVCC        5'h14
`define NODE_LDO         5'h15
`define NODE_LOGIC       5'h16
`define NODE_REFGND      5'h18
`define NODE_AGND        5'h19
`define NODE_DGND        5'h1A
`define NODE_DPC         5'h1B
`define NODE_AVDD2       5'h1C
`define NODE_AVSS        5'h1D
`define NODE_FAR_DIE     5'h1E
`define NODE_REFOUT      5'h1F

// Far-die sub-select encodings.
`define SUB_AGND         2'h0
`define SUB_INT_SUPPLY   2'h1
`define SUB_HIGH_SUPPLY  2'h2
`define SUB_RESERVED     2'h3

`endif

// ---- diag_adc_pkg.sv ----
`default_nettype none
package diag_adc_pkg;
    // Code-to-value scaling class of the node being converted.
    typedef enum logic [3:0] {
        SC_TEMP_MAIN,
        SC_TEMP_FAR,
        SC_FS_2V75,
        SC_FS_2V5,
        SC_FS_5V,
        SC_FS_10V,
        SC_FS_37V5,
        SC_SENSE_50V,
        SC_NEG_SUPPLY,
        SC_RESERVED
    } scale_t;
endpackage
`default_nettype wire

// ---- setup_cmd_if.sv ----
`default_nettype none
`include "diag_adc_defs.svh"
interface setup_cmd_if;
    logic                 wr;
    logic [`SETUP_W-1:0]  wdata;
    logic                 busy;
    logic                 fixed_ok;
    logic                 start;
    modport decode (
        input  wr,
        input  wdata,
        input  busy,
        output fixed_ok,
        output start
    );
    modport seq (
        output wr,
        output wdata,
        output busy,
        input  fixed_ok,
        input  start
    );
endinterface
`default_nettype wire

// ---- setup_cmd_decode.sv ----
`default_nettype none
`include "diag_adc_defs.svh"
module setup_cmd_decode (
    setup_cmd_if.decode cmd
);
    always_comb begin
        cmd.fixed_ok =
            (cmd.wdata[`SETUP_HI_MSB:`SETUP_HI_LSB] == `SETUP_HI_VAL) &&
            (cmd.wdata[`SETUP_LO_MSB:`SETUP_LO_LSB] == `SETUP_LO_VAL);
        cmd.start = cmd.wr && cmd.fixed_ok && !cmd.busy;
    end
endmodule
`default_nettype wire

// ---- node_route.sv ----
`default_nettype none
`include "diag_adc_defs.svh"
module node_route (
    input  wire logic               [4:0] node,
    input  wire logic               [1:0] sub,
    output var  logic                     far_en,
    output var  diag_adc_pkg::scale_t     scale
);
    always_comb begin
        far_en = 1'b0;
        if (node == `NODE_TEMP_MAIN) begin
            scale = diag_adc_pkg::SC_TEMP_MAIN;
        end else if (node == `NODE_TEMP_FAR) begin
            scale = diag_adc_pkg::SC_TEMP_FAR;
        end else if (node == `NODE_REFIN) begin
            scale = diag_adc_pkg::SC_FS_2V75;
        end else if (node == `NODE_SECOND_INTERNAL_REFERENCE || node == `NODE_REFGND ||
                     node == `NODE_AGND || node == `NODE_DGND ||
                     node == `NODE_REFOUT) begin
            scale = diag_adc_pkg::SC_FS_2V5;
        end else if (node == `NODE_SENSE_P || node == `NODE_SENSE_N) begin
            scale = diag_adc_pkg::SC_SENSE_50V;
        end else if (node == `NODE_AVCC || node == `NODE_LDO ||
                     node == `NODE_LOGIC) begin
            scale = diag_adc_pkg::SC_FS_10V;
        end else if (node == `NODE_DPC || node == `NODE_AVDD2) begin
            scale = diag_adc_pkg::SC_FS_37V5;
        end else if (node == `NODE_AVSS) begin
            scale = diag_adc_pkg::SC_NEG_SUPPLY;
        end else if (node == `NODE_FAR_DIE) begin
            far_en = (sub != `SUB_RESERVED);
            if (sub == `SUB_AGND) begin
                scale = diag_adc_pkg::SC_FS_2V5;
            end else if (sub == `SUB_INT_SUPPLY) begin
                scale = diag_adc_pkg::SC_FS_5V;
            end else if (sub == `SUB_HIGH_SUPPLY) begin
                scale = diag_adc_pkg::SC_FS_37V5;
            end else begin
                scale = diag_adc_pkg::SC_RESERVED;
            end
        end else begin
            scale = diag_adc_pkg::SC_RESERVED;
        end
    end
endmodule
`default_nettype wire

// ---- diag_adc_sequencer.sv ----
`default_nettype none
`include "diag_adc_defs.svh"
module diag_adc_sequencer #(
    parameter int CODE_W = 12,
    parameter int NODE_W = 5
) (
    input  wire logic                       clock,
    input  wire logic                       rst_b,
    input  wire logic                       setup_wr,
    input  wire logic [`SETUP_W-1:0]        setup_wdata,
    input  wire logic [1:0]                 far_die_node_subselect,
    input  wire logic                       conv_done,
    input  wire logic [CODE_W-1:0]          conv_code,
    output var  logic [`SETUP_W-1:0]        setup_r,
    output var  logic                       conv_start_r,
    output var  logic [NODE_W-1:0]          node_select_r,
    output var  logic                       far_route_en_r,
    output var  logic [1:0]                 far_sel_r,
    output var  diag_adc_pkg::scale_t       scale_r,
    output var  logic [`STAT_W-1:0]         status_word_r
);
    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } seq_state_t;

    seq_state_t                  state_r;
    seq_state_t                  state_nxt;
    logic [`SETUP_W-1:0]         setup_nxt;
    logic                        conv_start_nxt;
    logic [NODE_W-1:0]           node_select_nxt;
    logic [1:0]                  far_sel_nxt;
    logic                        far_route_en_nxt;
    diag_adc_pkg::scale_t        scale_nxt;
    logic [`STAT_W-1:0]          status_nxt;
    logic                        route_far_en;
    diag_adc_pkg::scale_t        route_scale;
    logic                        store;
    logic [NODE_W-1:0]           new_node;

    setup_cmd_if cmd ();

    assign cmd.wr    = setup_wr;
    assign cmd.wdata = setup_wdata;
    assign cmd.busy  = status_word_r[`STAT_BUSY_BIT];

    setup_cmd_decode u_decode (
        .cmd (cmd.decode)
    );

    assign new_node = setup_wdata[`SETUP_SEL_MSB:`SETUP_SEL_LSB];

    node_route u_route (
        .node   (new_node),
        .sub    (far_die_node_subselect),
        .far_en (route_far_en),
        .scale  (route_scale)
    );

    // A result is only taken while a conversion is outstanding, so a stray
    // done pulse from the converter can never overwrite a valid result.
    // A done pulse in the same cycle as the start pulse is legal: the
    // sequencer is already converting then and takes that result.
    assign store = (state_r == ST_CONVERT) && conv_done;

    // Setup register.
    always_comb begin
        setup_nxt = setup_r;
        if (setup_wr && !cmd.busy) begin
            setup_nxt = setup_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            setup_r <= `SETUP_RST;
        end else begin
            setup_r <= setup_nxt;
        end
    end

    // Conversion sequencer and converter routing.
    always_comb begin
        state_nxt        = state_r;
        conv_start_nxt   = 1'b0;
        node_select_nxt  = node_select_r;
        far_sel_nxt      = far_sel_r;
        far_route_en_nxt = far_route_en_r;
        scale_nxt        = scale_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd.start) begin
                    state_nxt        = ST_CONVERT;
                    conv_start_nxt   = 1'b1;
                    node_select_nxt  = new_node;
                    far_sel_nxt      = far_die_node_subselect;
                    far_route_en_nxt = route_far_en;
                    scale_nxt        = route_scale;
                end
            end
            ST_CONVERT: begin
                if (store) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r        <= ST_IDLE;
            conv_start_r   <= 1'b0;
            node_select_r  <= '0;
            far_sel_r      <= `SUB_AGND;
            far_route_en_r <= 1'b0;
            scale_r        <= diag_adc_pkg::SC_TEMP_MAIN;
        end else begin
            state_r        <= state_nxt;
            conv_start_r   <= conv_start_nxt;
            node_select_r  <= node_select_nxt;
            far_sel_r      <= far_sel_nxt;
            far_route_en_r <= far_route_en_nxt;
            scale_r        <= scale_nxt;
        end
    end

    // Status word. Busy, channel and result share one register so a frame
    // can never see a result paired with the wrong channel.
    always_comb begin
        status_nxt = status_word_r;
        if (cmd.start) begin
            status_nxt[`STAT_BUSY_BIT] = 1'b1;
        end
        if (store) begin
            status_nxt[`STAT_BUSY_BIT] = 1'b0;
            status_nxt[`STAT_CH_MSB:`STAT_CH_LSB] = node_select_r;
            status_nxt[`STAT_DATA_MSB:`STAT_DATA_LSB] = conv_code;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            status_word_r <= `STAT_RST;
        end else begin
            status_word_r <= status_nxt;
        end
    end

    // Every check below runs on the one clock and rests while reset is low.
    default clocking dflt_cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    AST_SEL_FIELD:
        assert property (cmd.start |=> node_select_r == $past(new_node))
        else $error("Node select not taken from setup bits.");

    AST_START_ONE:
        assert property (cmd.start |=> conv_start_r ##1 !conv_start_r)
        else $error("Accepted setup write did not give one start pulse.");

    AST_BAD_PATTERN:
        assert property (setup_wr && !cmd.fixed_ok |=> !conv_start_r)
        else $error("Setup write with wrong fixed bits started a conversion.");

    AST_RESULT_STORE:
        assert property (store |=>
            status_word_r[`STAT_DATA_MSB:`STAT_DATA_LSB] == $past(conv_code))
        else $error("Completed result not placed in status.");

    AST_RESULT_HOLD:
        assert property (!store |=>
            $stable(status_word_r[`STAT_CH_MSB:`STAT_DATA_LSB]))
        else $error("Status result changed without a completed conversion.");

    AST_CHANNEL_TAG:
        assert property (store |=>
            status_word_r[`STAT_CH_MSB:`STAT_CH_LSB] == node_select_r)
        else $error("Stored channel differs from converted node.");

    AST_BUSY_FRAME:
        assert property (conv_start_r |->
            status_word_r[`STAT_BUSY_BIT] &&
            $stable(status_word_r[`STAT_DATA_MSB:`STAT_DATA_LSB]))
        else $error("Status during conversion lost busy or old result.");

    AST_IGNORE_BUSY:
        assert property (setup_wr && status_word_r[`STAT_BUSY_BIT] |=>
            !conv_start_r && $stable(setup_r))
        else $error("Command taken while converter busy.");

    AST_FAR_ROUTE:
        assert property (conv_start_r && node_select_r == `NODE_FAR_DIE |->
            far_route_en_r == (far_sel_r != `SUB_RESERVED) &&
            far_sel_r == $past(far_die_node_subselect))
        else $error("Far-die node not routed by sub-select.");

    AST_SECOND_INTERNAL_REFERENCE_SCALE:
        assert property (conv_start_r && node_select_r == `NODE_SECOND_INTERNAL_REFERENCE |->
            scale_r == diag_adc_pkg::SC_FS_2V5 && !far_route_en_r)
        else $error("Second reference node given wrong scaling.");

    AST_HIGH_SCALE:
        assert property (conv_start_r && node_select_r == `NODE_DPC |->
            scale_r == diag_adc_pkg::SC_FS_37V5)
        else $error("Divided supply node given wrong scaling.");

    AST_BUSY_RISE:
        assert property (cmd.start |=>
            status_word_r[`STAT_BUSY_BIT] && state_r == ST_CONVERT)
        else $error("Busy did not rise with conversion start.");

    AST_BUSY_FALL:
        assert property ($fell(status_word_r[`STAT_BUSY_BIT]) |->
            $past(store) && !$stable(state_r))
        else $error("Busy fell without a stored result.");

    AST_BUSY_STATE:
        assert property (status_word_r[`STAT_BUSY_BIT] ==
            (state_r == ST_CONVERT))
        else $error("Busy bit disagrees with sequencer state.");

    AST_START_DONE:
        assert property (cmd.start ##1 conv_done ##1
            (conv_done && !setup_wr) |=>
            !status_word_r[`STAT_BUSY_BIT] && !conv_start_r &&
            $stable(status_word_r[`STAT_CH_MSB:`STAT_DATA_LSB]))
        else $error("One write produced more than one conversion.");

    AST_SETUP_STORE:
        assert property (setup_wr && !cmd.busy |=>
            setup_r == $past(setup_wdata))
        else $error("Setup write while idle not stored.");

    AST_START_CAUSE:
        assert property (conv_start_r |-> $past(cmd.start))
        else $error("Start pulse without an accepted setup write.");

    AST_NODE_HOLD:
        assert property (!cmd.start |=>
            $stable({node_select_r, far_sel_r, far_route_en_r, scale_r}))
        else $error("Routing changed without an accepted start.");

    AST_FAR_RESERVED:
        assert property (conv_start_r && far_sel_r == `SUB_RESERVED |->
            !far_route_en_r)
        else $error("Reserved sub-select routed to the far die.");

    AST_FAR_ONLY:
        assert property (far_route_en_r |-> node_select_r == `NODE_FAR_DIE)
        else $error("Far-die route enabled for a local node.");

    AST_SCALE_FAR:
        assert property (conv_start_r && node_select_r == `NODE_FAR_DIE &&
            far_sel_r == `SUB_INT_SUPPLY |-> scale_r == diag_adc_pkg::SC_FS_5V)
        else $error("Far-die internal supply given wrong scaling.");

    AST_IDLE_DONE:
        assert property (conv_done && state_r == ST_IDLE && !cmd.start |=>
            $stable(status_word_r))
        else $error("Done pulse while idle changed the status word.");

    AST_STORE_CLEAR:
        assert property (store |=> !status_word_r[`STAT_BUSY_BIT])
        else $error("Busy still set after a stored result.");

    COV_CONVERSION: cover property (cmd.start ##[1:20] store);
    COV_IGNORED: cover property (
        status_word_r[`STAT_BUSY_BIT] && setup_wr && cmd.fixed_ok);
    COV_FAR_DIE: cover property (
        conv_start_r && node_select_r == `NODE_FAR_DIE && far_route_en_r);
    COV_BAD_WRITE: cover property (setup_wr && !cmd.fixed_ok);
    COV_EARLY_DONE: cover property (conv_start_r && conv_done);
endmodule
`default_nettype wire

// ---- conv_model.sv ----
`default_nettype none
module conv_model (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic [7:0]  lat,
    input  wire logic [11:0] code_in,
    input  wire logic        spur,
    output var  logic        conv_done,
    output var  logic [11:0] conv_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  cnt_r;
    logic [11:0] code_r;
    // Between results the code lines toggle, so the last result shows again only on every second cycle.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r     <= 8'h00;
            code_r    <= 12'h000;
            conv_done <= 1'b0;
            conv_code <= 12'hA5A;
        end else begin
            conv_done <= spur;
            conv_code <= ~conv_code;
            if (start) begin
                cnt_r  <= lat;
                code_r <= code_in;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    conv_done <= 1'b1;
                    conv_code <= code_r;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- diag_adc_sequencer_tb.sv ----
`default_nettype none
`include "diag_adc_defs.svh"
module diag_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock, rst_b, setup_wr, spur, conv_done;
    logic [`SETUP_W-1:0]   setup_wdata, setup_r;
    logic [1:0]            sub, far_sel_r;
    logic [11:0]           conv_code, code_in;
    logic [7:0]            lat;
    logic                  conv_start_r, far_route_en_r, busy_q;
    logic [4:0]            node_select_r;
    diag_adc_pkg::scale_t  scale_r;
    logic [`STAT_W-1:0]    status_word_r, prev;
    logic [`STAT_W-1:0]    exp_q[$];
    int                    n_errors, tests_run;
    logic [4:0] nodes [21] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h0D,
        5'h0E, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C,
        5'h1D, 5'h1E, 5'h1E, 5'h1E, 5'h1E, 5'h1F};

    diag_adc_sequencer u_diag_adc_sequencer (
        .clock(clock), .rst_b(rst_b), .setup_wr(setup_wr),
        .setup_wdata(setup_wdata), .far_die_node_subselect(sub),
        .conv_done(conv_done), .conv_code(conv_code), .setup_r(setup_r),
        .conv_start_r(conv_start_r), .node_select_r(node_select_r),
        .far_route_en_r(far_route_en_r), .far_sel_r(far_sel_r),
        .scale_r(scale_r), .status_word_r(status_word_r));
    conv_model u_conv_model (
        .clock(clock), .rst_b(rst_b), .start(conv_start_r), .lat(lat),
        .code_in(code_in), .spur(spur), .conv_done(conv_done),
        .conv_code(conv_code));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic diag_adc_pkg::scale_t exp_scale(logic [4:0] n,
                                                        logic [1:0] s);
        case (n)
            5'h00: return diag_adc_pkg::SC_TEMP_MAIN;
            5'h01: return diag_adc_pkg::SC_TEMP_FAR;
            5'h03: return diag_adc_pkg::SC_FS_2V75;
            5'h04, 5'h18, 5'h19, 5'h1A, 5'h1F: return diag_adc_pkg::SC_FS_2V5;
            5'h0D, 5'h0E: return diag_adc_pkg::SC_SENSE_50V;
            5'h14, 5'h15, 5'h16: return diag_adc_pkg::SC_FS_10V;
            5'h1B, 5'h1C: return diag_adc_pkg::SC_FS_37V5;
            5'h1D: return diag_adc_pkg::SC_NEG_SUPPLY;
            5'h1E: case (s)
                2'h0: return diag_adc_pkg::SC_FS_2V5;
                2'h1: return diag_adc_pkg::SC_FS_5V;
                2'h2: return diag_adc_pkg::SC_FS_37V5;
                default: return diag_adc_pkg::SC_RESERVED;
            endcase
            default: return diag_adc_pkg::SC_RESERVED;
        endcase
    endfunction

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 300; k++) begin
            @(negedge clock);
            if (status_word_r[17] === 1'b0) return;
        end
        n_errors++;
        $display("[FAIL] busy expected 0 seen 1");
        stop_test();
    endtask

    task automatic write(logic [`SETUP_W-1:0] d);
        @(posedge clock);
        setup_wr    <= 1'b1;
        setup_wdata <= d;
        @(posedge clock);
        setup_wr <= 1'b0;
        #1;
    endtask

    task automatic convert(logic [4:0] n, logic [1:0] s, logic [7:0] l,
                           bit wait_done);
        @(posedge clock);
        sub     <= s;
        lat     <= l;
        code_in <= 12'($urandom);
        @(posedge clock);
        #1;
        prev = status_word_r;
        write({3'h4, 3'h0, n});
        check("start", 1, conv_start_r);
        check("busy", 1, status_word_r[17]);
        check("old result", prev[16:0], status_word_r[16:0]);
        check("node", n, node_select_r);
        check("scale", exp_scale(n, s), scale_r);
        check("far route", n == 5'h1E && s != 2'h3, far_route_en_r);
        check("far sel", s, far_sel_r);
        check("setup", {3'h4, 3'h0, n}, setup_r);
        exp_q.push_back({1'b0, n, code_in});
        @(posedge clock);
        #1;
        check("start pulse", 0, conv_start_r);
        if (wait_done) wait_idle();
    endtask

    // Result monitor: every busy fall must deliver the oldest expectation.
    always @(negedge clock) begin
        if (!rst_b) begin
            busy_q = 1'b0;
        end else begin
            if (busy_q === 1'b1 && status_word_r[17] === 1'b0) begin
                if (exp_q.size() == 0) begin
                    check("unexpected result", 0, 1);
                end else begin
                    check("status", exp_q.pop_front(), status_word_r);
                end
            end
            busy_q = status_word_r[17];
        end
    end

    initial begin
        rst_b = 1'b0; setup_wr = 1'b0; setup_wdata = '0; spur = 1'b0;
        sub = 2'h0; lat = 8'h01; code_in = 12'h000;
        n_errors = 0; tests_run = 0;
        void'($urandom(99));
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("reset setup", 11'h400, setup_r);
        check("reset status", 0, status_word_r);
        $display("Test reset done");
        for (int i = 0; i < 21; i++) begin
            convert(nodes[i], nodes[i] == 5'h1E ? 2'(i - 16) : 2'($urandom),
                    8'(1 + (i % 2) * 15), 1);
        end
        $display("Test node table done");
        convert(5'h0D, 2'h0, 8'h14, 0);
        prev = status_word_r;
        write(11'h41F);
        check("busy write start", 0, conv_start_r);
        check("busy write setup", {3'h4, 3'h0, 5'h0D}, setup_r);
        check("busy word", prev, status_word_r);
        wait_idle();
        $display("Test busy write done");
        prev = status_word_r;
        write(11'h2A5);
        check("bad pattern setup", 11'h2A5, setup_r);
        check("bad pattern start", 0, conv_start_r);
        @(posedge clock);
        spur <= 1'b1;
        @(posedge clock);
        spur <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("idle done", prev, status_word_r);
        $display("Test refusals done");
        convert(5'h04, 2'h1, 8'h03, 0);
        for (int k = 0; k < 50 && conv_done !== 1'b1; k++) @(negedge clock);
        if (conv_done !== 1'b1) begin
            n_errors++;
            $display("[FAIL] conv_done expected 1 seen 0");
            stop_test();
        end
        @(posedge clock);
        code_in     <= 12'($urandom);
        setup_wr    <= 1'b1;
        setup_wdata <= 11'h41F;
        @(posedge clock);
        setup_wr <= 1'b0;
        exp_q.push_back({1'b0, 5'h1F, code_in});
        #1;
        check("back to back start", 1, conv_start_r);
        check("back to back node", 5'h1F, node_select_r);
        wait_idle();
        #1;
        check("queue empty", 0, exp_q.size());
        $display("Test back to back done");
        @(posedge clock);
        spur        <= 1'b1;
        setup_wr    <= 1'b1;
        setup_wdata <= 11'h403;
        @(posedge clock);
        setup_wr <= 1'b0;
        @(negedge clock);
        exp_q.push_back({1'b0, 5'h03, conv_code});
        @(posedge clock);
        spur <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("early done busy", 0, status_word_r[17]);
        check("early done start", 0, conv_start_r);
        check("early done queue", 0, exp_q.size());
        $display("Test early done done");
        convert(5'h19, 2'h0, 8'h28, 0);
        rst_b <= 1'b0;
        #1;
        check("second reset status", 0, status_word_r);
        check("second reset setup", 11'h400, setup_r);
        exp_q.delete();
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("second reset start", 0, conv_start_r);
        check("second reset node", 0, node_select_r);
        convert(5'h1E, 2'h2, 8'h05, 1);
        #1;
        check("second reset queue", 0, exp_q.size());
        $display("Test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire
